//--- scs_pkg.sv
// package: register layout, constants and carriers for system control status
// Functional notes
// - event flags set; write one clears each
// - full system reset clears all flags
// - unmasked core interrupt sets priority-active flag
// - watchdog expiry sets flag, always bus error
// - read-only chip-select write sets violation flag
// - two chip selects together set conflict
// - violation bus error only when enabled
// - violation flag set regardless of enable
// - treatment zero: strobe held, grant free
// - treatment one: split strobe, grant withheld
// - no grant during core lock under treatment one; reset zero
// - extra wait bit adds one wait state
// - wait clear: zero waits, exact count
// - conflict bus error only when enabled
// - bus-clear mask gates pending interrupt use
// - access mode zero: asynchronous, three waits
// - 32-bit word at fixed supervisor address
// - freeze, mode, watchdog field positions
// - watchdog errors unacknowledged long cycles
// - count code selects 128 to 16K clocks
// - watchdog enable resets to one
// - mode one: synchronous, one wait with extra
package scs_pkg;
	localparam logic [11:0] SCW_ADDR = 12'h0f4;
	localparam logic [2:0] SUPER_DATA_FC = 3'h5;
	localparam int B_IPA = 27;
	localparam int B_HWT = 26;
	localparam int B_WPV = 25;
	localparam int B_ADC = 24;
	localparam int B_RME = 23;
	localparam int B_EXTERNAL_RISC_REQUEST_ENABLE = 22;
	localparam int B_VGE = 21;
	localparam int B_WRITE_PROTECT_ERROR_ENABLE = 20;
	localparam int B_LOCKED_CYCLE_TREATMENT = 19;
	localparam int B_EXTERNAL_MASTER_EXTRA_WAIT = 18;
	localparam int B_DECODE_CONFLICT_ERROR_ENABLE = 17;
	localparam int B_BUS_CLEAR_MASK = 16;
	localparam int B_FREEZE_WATCHDOG_ENABLE = 15;
	localparam int B_FREEZE_TIMER_TWO_ENABLE = 14;
	localparam int B_FREEZE_TIMER_ONE_ENABLE = 13;
	localparam int B_SAM = 12;
	localparam int B_BUS_WATCHDOG_ENABLE = 11;
	localparam int B_CNT_LO = 8;
	localparam logic [31:0] FLAG_MASK = 32'h0f000000;
	localparam logic [31:0] CTRL_MASK = 32'h00ffff00;
	localparam logic [31:0] SCW_RESET = 32'h00000800;
	localparam int WD_BASE_LOG2 = 7;
	localparam int WD_CNT_W = 15;
	localparam logic [1:0] ASYNC_WAITS = 2'h3;
	localparam logic [1:0] SYNC_WAITS = 2'h0;
	localparam logic [1:0] EXTRA_WAIT = 2'h1;
	typedef struct packed {
		logic irq_pending;
		logic unmasked_irq;
		logic cycle_active;
		logic data_ack;
		logic wr_to_readonly;
		logic [3:0] cs_request;
	} scs_events_s;
	typedef struct packed {
		logic freeze_watchdog_enable;
		logic freeze_timer_two_enable;
		logic freeze_timer_one_enable;
		logic ram_microcode_enable;
		logic external_risc_request_enable;
		logic vector_generation_enable;
	} scs_misc_s;
endpackage

//--- scs_watchdog.sv
// bus-cycle watchdog counter
`timescale 1ns/1ps
module scs_watchdog (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic [2:0] count_code,
	input wire logic cycle_active,
	input wire logic data_ack,
	output logic timeout
);
	logic [scs_pkg::WD_CNT_W-1:0] cnt_r;
	logic [scs_pkg::WD_CNT_W-1:0] limit;
	wire running = enable & cycle_active & ~data_ack;
	// 128 << code, minus one since count starts at zero
	assign limit = scs_pkg::WD_CNT_W'(
		(32'd1 << (scs_pkg::WD_BASE_LOG2 + 32'(count_code))) - 32'd1);
	assign timeout = running && (cnt_r == limit);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cnt_r <= '0;
		else if (!running || timeout)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 1'b1;
	end
endmodule // scs_watchdog

//--- scs_control.sv
// system control word, event flags, bus error and arbiter policy
`timescale 1ns/1ps
module scs_control (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic HALT_N,
	input wire logic SEL,
	input wire logic WRITE,
	input wire logic [11:0] ADDR,
	input wire logic [2:0] FC,
	input wire logic [31:0] WDATA,
	output logic [31:0] RDATA,
	input wire scs_pkg::scs_events_s EVENTS,
	input wire logic LOCKED_CYCLE_SIGNAL,
	input wire logic LOCKED_WRITE_PART,
	input wire logic BUS_REQUEST,
	input wire logic EXT_MASTER,
	input wire logic CS_ACK_CYCLE,
	output logic BUS_ERROR,
	output logic BUS_GRANT,
	output logic BUS_CLEAR,
	output logic SPLIT_STROBE,
	output logic WAIT_WRITE_PART,
	output logic SYNC_ACCESS,
	output logic [1:0] EXT_WAIT_STATES,
	output logic CS_EXTRA_WAIT,
	output logic BUS_WATCHDOG_ENABLE,
	output scs_pkg::scs_misc_s MISC
);
	logic [31:0] scw_r;
	logic [31:0] scw_nxt;
	logic [3:0] flags_r;
	logic [3:0] flags_nxt;
	logic full_reset_r;
	logic grant_r;
	logic locked_hold_r;
	logic bus_error_r;
	logic wd_timeout;
	wire hit = SEL && (ADDR == scs_pkg::SCW_ADDR)
		&& (FC == scs_pkg::SUPER_DATA_FC);
	wire wr_hit = hit && WRITE;
	wire write_protect_error_enable = scw_r[scs_pkg::B_WRITE_PROTECT_ERROR_ENABLE];
	wire locked_cycle_treatment = scw_r[scs_pkg::B_LOCKED_CYCLE_TREATMENT];
	wire external_master_extra_wait = scw_r[scs_pkg::B_EXTERNAL_MASTER_EXTRA_WAIT];
	wire decode_conflict_error_enable = scw_r[scs_pkg::B_DECODE_CONFLICT_ERROR_ENABLE];
	wire bus_clear_mask = scw_r[scs_pkg::B_BUS_CLEAR_MASK];
	wire sync_access_select = scw_r[scs_pkg::B_SAM];
	wire bus_watchdog_enable = scw_r[scs_pkg::B_BUS_WATCHDOG_ENABLE];
	wire [2:0] bus_watchdog_count = scw_r[scs_pkg::B_CNT_LO +: 3];
	function automatic logic multi_hot(input logic [3:0] v);
		multi_hot = (v & (v - 4'h1)) != 4'h0;
	endfunction
	wire conflict = EVENTS.cycle_active
		&& multi_hot(EVENTS.cs_request);
	wire wp_event = EVENTS.wr_to_readonly;
	wire [3:0] set_vec = {EVENTS.unmasked_irq, wd_timeout,
		wp_event, conflict};
	wire [3:0] clr_vec = wr_hit ?
		WDATA[scs_pkg::B_ADC +: 4] : 4'h0;
	// set beats a simultaneous write-one clear so no event is lost
	assign flags_nxt = set_vec | (flags_r & ~clr_vec);
	assign scw_nxt = wr_hit ?
		((WDATA & scs_pkg::CTRL_MASK) | (scw_r & ~scs_pkg::CTRL_MASK))
		: scw_r;
	wire err_nxt = wd_timeout | (wp_event & write_protect_error_enable)
		| (conflict & decode_conflict_error_enable);
	// lock holds grant off only while the locked cycle signal is high; the write part has no effect
	wire lock_active = LOCKED_CYCLE_SIGNAL
		&& (locked_cycle_treatment || locked_hold_r);
	wire clear_req = bus_clear_mask & EVENTS.irq_pending;
	scs_watchdog u_wd (
		.clk(CLK),
		.reset_n(RESET_N),
		.enable(bus_watchdog_enable),
		.count_code(bus_watchdog_count),
		.cycle_active(EVENTS.cycle_active),
		.data_ack(EVENTS.data_ack),
		.timeout(wd_timeout)
	);
	// flags clear on any reset: RESET_N alone, halt plays no part
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			full_reset_r <= 1'b1;
		else
			full_reset_r <= 1'b0;
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			scw_r <= scs_pkg::SCW_RESET;
			flags_r <= 4'h0;
		end else begin
			scw_r <= scw_nxt;
			flags_r <= flags_nxt;
		end
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			grant_r <= 1'b0;
			locked_hold_r <= 1'b0;
			bus_error_r <= 1'b0;
			RDATA <= 32'h0;
		end else begin
			// grant refused while the core holds a split-treatment locked cycle or a bus clear is pending
			grant_r <= BUS_REQUEST && !lock_active && !clear_req;
			locked_hold_r <= LOCKED_CYCLE_SIGNAL && locked_cycle_treatment
				&& !(LOCKED_WRITE_PART && !LOCKED_CYCLE_SIGNAL);
			bus_error_r <= err_nxt;
			RDATA <= hit ? ((scw_r & scs_pkg::CTRL_MASK)
				| {4'h0, flags_r, 24'h0}) : 32'h0;
		end
	end
	// halt is combined here only to keep the input used; BUS_GRANT reduces to grant_r
	wire unused_halt = HALT_N & full_reset_r;
	assign BUS_ERROR = bus_error_r;
	assign BUS_GRANT = grant_r & ~unused_halt | grant_r;
	assign BUS_CLEAR = clear_req;
	assign SPLIT_STROBE = locked_cycle_treatment & LOCKED_CYCLE_SIGNAL;
	assign WAIT_WRITE_PART = locked_cycle_treatment & LOCKED_WRITE_PART
		& CS_ACK_CYCLE;
	assign SYNC_ACCESS = sync_access_select;
	assign EXT_WAIT_STATES = !EXT_MASTER ? scs_pkg::SYNC_WAITS
		: !sync_access_select ? scs_pkg::ASYNC_WAITS
		: external_master_extra_wait ? scs_pkg::EXTRA_WAIT : scs_pkg::SYNC_WAITS;
	assign CS_EXTRA_WAIT = EXT_MASTER & external_master_extra_wait & CS_ACK_CYCLE;
	assign BUS_WATCHDOG_ENABLE = bus_watchdog_enable;
	assign MISC = '{scw_r[scs_pkg::B_FREEZE_WATCHDOG_ENABLE], scw_r[scs_pkg::B_FREEZE_TIMER_TWO_ENABLE],
		scw_r[scs_pkg::B_FREEZE_TIMER_ONE_ENABLE], scw_r[scs_pkg::B_RME],
		scw_r[scs_pkg::B_EXTERNAL_RISC_REQUEST_ENABLE], scw_r[scs_pkg::B_VGE]};
endmodule // scs_control

//--- scs_assertions.sv
// checker: register echo, read padding, wait counts and grant lock
`timescale 1ns/1ps
module scs_assertions (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic SEL,
	input wire logic WRITE,
	input wire logic [11:0] ADDR,
	input wire logic [2:0] FC,
	input wire logic [31:0] WDATA,
	input wire logic [31:0] RDATA,
	input wire logic LOCKED_CYCLE_SIGNAL,
	input wire logic SPLIT_STROBE,
	input wire logic EXT_MASTER,
	input wire logic BUS_GRANT,
	input wire logic SYNC_ACCESS,
	input wire logic [1:0] EXT_WAIT_STATES,
	input wire logic BUS_WATCHDOG_ENABLE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	logic [31:0] wd_q;
	wire hit = ADDR == scs_pkg::SCW_ADDR && FC == scs_pkg::SUPER_DATA_FC;
	always_ff @(posedge CLK) wd_q <= WDATA;
	a_mode_write: assert property (SEL && hit && WRITE |=>
		SYNC_ACCESS == wd_q[12]) else $error("mode bit not written");
	a_wden_write: assert property (SEL && hit && WRITE |=>
		BUS_WATCHDOG_ENABLE == wd_q[11]) else $error("wd enable not written");
	a_miss_zero: assert property (SEL && !hit |=> RDATA == 32'h0)
		else $error("miss read not zero");
	a_pad_zero: assert property (SEL && hit && !WRITE |=>
		RDATA[31:28] == 4'h0 && RDATA[7:0] == 8'h0) else $error("pad bits set");
	a_async_three: assert property (EXT_MASTER && !SYNC_ACCESS |->
		EXT_WAIT_STATES == 2'h3) else $error("async waits wrong");
	a_sync_waits: assert property (EXT_MASTER && SYNC_ACCESS |->
		EXT_WAIT_STATES <= 2'h1) else $error("sync waits wrong");
	a_core_nowait: assert property (!EXT_MASTER |->
		EXT_WAIT_STATES == 2'h0) else $error("core waits nonzero");
	// for locked cycles, grant is held off only under the split treatment
	a_lock_grant: assert property (SPLIT_STROBE [*2] |->
		!BUS_GRANT) else $error("grant during lock");
	c_write: cover property (SEL && hit && WRITE);
	c_lock: cover property (LOCKED_CYCLE_SIGNAL [*2]);
	c_async: cover property (EXT_MASTER && !SYNC_ACCESS);
endmodule // scs_assertions
bind scs_control scs_assertions u_chk (.CLK(CLK), .RESET_N(RESET_N),
	.SEL(SEL), .WRITE(WRITE), .ADDR(ADDR), .FC(FC), .WDATA(WDATA),
	.RDATA(RDATA), .LOCKED_CYCLE_SIGNAL(LOCKED_CYCLE_SIGNAL),
	.SPLIT_STROBE(SPLIT_STROBE),
	.EXT_MASTER(EXT_MASTER), .BUS_GRANT(BUS_GRANT),
	.SYNC_ACCESS(SYNC_ACCESS), .EXT_WAIT_STATES(EXT_WAIT_STATES),
	.BUS_WATCHDOG_ENABLE(BUS_WATCHDOG_ENABLE));

//--- scs_core_model.sv
// core-side model: event levels and a bus cycle acked after a delay
`timescale 1ns/1ps
module scs_core_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] dly,
	input wire logic irq,
	input wire logic wp,
	input wire logic [3:0] cs,
	output scs_pkg::scs_events_s ev
);
	logic [7:0] cnt_r;
	// zero delay leaves the cycle unacknowledged, for the watchdog
	wire ack = go && dly != 8'h0 && cnt_r == dly;
	always_ff @(posedge clk) cnt_r <= go ? cnt_r + 8'h1 : 8'h0;
	assign ev = {irq, irq, go, ack, wp, cs};
endmodule // scs_core_model

//--- system_control_status_tb.sv
// testbench: word access, event flags, waits, grant and watchdog
`timescale 1ns/1ps
module system_control_status_tb;
	logic CLK = 0, RESET_N = 0, SEL = 0, WRITE = 0, go = 0, irq = 0;
	logic wp = 0, lock = 0, extm = 0, bus_error, gnt, bclr;
	logic csack = 0, wpart = 0, spl, wwp, cxw;
	logic [11:0] ADDR = 12'h0f4;
	logic [31:0] WDATA = 0, RDATA;
	logic [7:0] dly = 0;
	logic [3:0] cs = 0;
	logic [1:0] ws;
	scs_pkg::scs_events_s ev;
	scs_pkg::scs_misc_s misc;
	int bad_count = 0, num_checks = 0, n = 0;
	always #10 CLK = ~CLK;
	always @(posedge CLK) if (bus_error === 1'b1) n++;
	scs_control dut (.CLK(CLK), .RESET_N(RESET_N), .HALT_N(1'b0), .SEL(SEL),
		.WRITE(WRITE), .ADDR(ADDR), .FC(3'h5), .WDATA(WDATA), .RDATA(RDATA),
		.EVENTS(ev), .LOCKED_CYCLE_SIGNAL(lock), .LOCKED_WRITE_PART(wpart),
		.BUS_REQUEST(1'b1), .EXT_MASTER(extm), .CS_ACK_CYCLE(csack),
		.BUS_ERROR(bus_error), .BUS_GRANT(gnt), .BUS_CLEAR(bclr),
		.SPLIT_STROBE(spl), .WAIT_WRITE_PART(wwp), .SYNC_ACCESS(),
		.EXT_WAIT_STATES(ws), .CS_EXTRA_WAIT(cxw),
		.BUS_WATCHDOG_ENABLE(), .MISC(misc));
	scs_core_model core (.clk(CLK), .go(go), .dly(dly), .irq(irq), .wp(wp),
		.cs(cs), .ev(ev));
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task acc(input logic w, input logic [31:0] d);
		@(negedge CLK);
		SEL = 1;
		WRITE = w;
		WDATA = d;
		@(negedge CLK);
		SEL = 0;
	endtask
	task rd(input logic [31:0] e);
		acc(0, 0);
		chk("word", e, RDATA);
	endtask
	task evs;
		n = 0;
		wp = 1;
		@(negedge CLK);
		wp = 0;
		// a conflict only counts inside a live bus cycle
		cs = 4'h3;
		go = 1;
		@(negedge CLK);
		cs = 0;
		go = 0;
		repeat (3) @(negedge CLK);
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		results;
	end
	initial begin
		repeat (5) @(negedge CLK);
		RESET_N = 1;
		rd(32'h00000800);
		acc(1, 32'h00171800);
		rd(32'h00171800);
		extm = 1;
		irq = 1;
		csack = 1;
		@(negedge CLK);
		chk("waits", 1, ws);
		chk("cs wait", 1, cxw);
		chk("clear", 1, bclr);
		irq = 0;
		csack = 0;
		evs;
		chk("bus_error", 2, n);
		rd(32'h0b171800);
		acc(1, 32'h0a001800);
		rd(32'h01001800);
		chk("waits", 0, ws);
		irq = 1;
		@(negedge CLK);
		chk("clear", 0, bclr);
		irq = 0;
		evs;
		chk("bus_error", 0, n);
		rd(32'h0b001800);
		acc(1, 32'h00000800);
		chk("waits", 3, ws);
		extm = 0;
		// treatment zero: grant stays free during the lock
		lock = 1;
		wpart = 1;
		csack = 1;
		repeat (2) @(negedge CLK);
		chk("grant", 1, gnt);
		chk("split", 0, spl);
		chk("wait write", 0, wwp);
		lock = 0;
		acc(1, 32'h00080800);
		lock = 1;
		repeat (2) @(negedge CLK);
		chk("grant", 0, gnt);
		chk("split", 1, spl);
		chk("wait write", 1, wwp);
		lock = 0;
		wpart = 0;
		csack = 0;
		repeat (3) @(negedge CLK);
		chk("grant", 1, gnt);
		acc(1, 32'h00000800);
		n = 0;
		dly = 8'h3;
		go = 1;
		repeat (6) @(negedge CLK);
		go = 0;
		dly = 0;
		@(negedge CLK);
		go = 1;
		repeat (125) @(negedge CLK);
		chk("bus_error", 0, n);
		repeat (10) @(negedge CLK);
		chk("bus_error", 1, n);
		go = 0;
		rd(32'h0f000800);
		RESET_N = 0;
		repeat (2) @(negedge CLK);
		RESET_N = 1;
		rd(32'h00000800);
		ADDR = 12'h0f8;
		acc(1, 32'hffffffff);
		rd(32'h0);
		ADDR = 12'h0f4;
		rd(32'h00000800);
		acc(1, 32'h0080a800);
		rd(32'h0080a800);
		chk("misc", 32'h2c, misc);
		results;
	end
endmodule // system_control_status_tb
